/* verilog/lmd_map.svh */
// Offsets, field positions, reset values and timing figures of the LED matrix display link.
`ifndef LMD_MAP_SVH
`define LMD_MAP_SVH
// Core clock rate in MHz.
`define LMD_CLK_MHZ 10
// Length of one column or key-scan slot in microseconds.
`define LMD_SLOT_US 1056
// All-off gap at the start of each column slot in microseconds.
`define LMD_BLANK_US 16
// Blink base tick (quarter of a 1 Hz period) in milliseconds.
`define LMD_BLINK_TICK_MS 250
// Half period of the link clock in core cycles (host end divider).
`define LMD_LNK_HALF 4'h8
// Reset value of the display configuration command byte.
`define LMD_DISP_CFG_RST 8'h80
// Field positions inside the display configuration byte.
`define LMD_CFG_EN 0
`define LMD_CFG_BLINK_LO 1
`define LMD_CFG_BLINK_HI 2
// System configuration oscillator-on bit.
`define LMD_SYS_OSC 0
// Number of display RAM bytes; pointers below this reach display RAM.
`define LMD_RAM_WORDS 7'h10
// Slot index of the key-scan slot in the nine-slot frame.
`define LMD_KEYSCAN_SLOT 4'h8
// Host register word indices on the Avalon-MM slave.
`define LMD_REG_TX 2'h0
`define LMD_REG_STAT 2'h1
// Host transmit register fields.
`define LMD_TX_LAST 8
`define LMD_TX_READ 9
// Host status register fields.
`define LMD_ST_BUSY 0
`define LMD_ST_OPEN 1
`define LMD_ST_RDATA 8
`endif

/* verilog/lmd_pkg.sv */
// Types shared by both ends of the LED matrix display link.
package lmd_pkg;
  // Upper nibble of a command byte.
  typedef enum logic [3:0] {
    LMD_CMD_DPTR = 4'h0,
    LMD_CMD_SYS = 4'h2,
    LMD_CMD_KPTR = 4'h4,
    LMD_CMD_FPTR = 4'h6,
    LMD_CMD_DISP = 4'h8
  } lmd_cmd_e;
  // Host link sequencer states.
  typedef enum logic [1:0] {
    LMD_H_IDLE = 2'b00,
    LMD_H_LOW = 2'b01,
    LMD_H_HIGH = 2'b10,
    LMD_H_CLOSE = 2'b11
  } lmd_hst_e;
endpackage

/* verilog/lmd_link_if.sv */
// Serial link between the host controller and the display device.
`timescale 1ns/1ns
interface lmd_link_if;
  logic lnkClk; // Link clock, made by the host, idles high.
  logic lnkSelN; // Frame select, low for the length of a frame.
  logic lnkH2d; // Host to device data, changed on falling link clock.
  logic lnkD2h; // Device to host data, changed on falling link clock.
  modport host(output lnkClk, output lnkSelN, output lnkH2d, input lnkD2h);
  modport dev(input lnkClk, input lnkSelN, input lnkH2d, output lnkD2h);
endinterface

/* verilog/lmd_dev_end.sv */
// Display end: command decode, display RAM and multiplexed row/column drive.
//
// Overview of operation
// - Display enable bit turns LED output on/off.
// - Display off: rows and columns float.
// - Off during key scan: rows input, columns 0-3 scan.
// - Display byte: 1000, x, two blink bits, enable.
// - Blink field: off, 2Hz, 1Hz, 0.5Hz.
// - Blink rates divide the system clock.
// - Oscillator stays stopped after reset until commanded.
// - Frame timing comes from the system clock.
// - Pointer command, then display bytes stored consecutively.
// - Key data reached through the same pointer.
// - Registers and flag reached through the pointer.
// - Sixteen rows follow RAM of current column.
// - Eight columns sequenced by drive mode.
// - 16x8 display RAM, one means LED on.
// - Column n: even byte rows 0-7, odd 8-15.
// - Nine 1056us slots: eight columns, one key scan.
// - Standby ignores every write except system command; read frames still answer.
// - System byte 0010 nibble, bit 0 starts oscillator.
`timescale 1ns/1ns
`include "lmd_map.svh"
module lmd_dev_end import lmd_pkg::*; #(
  parameter int SLOT_CYC = `LMD_SLOT_US * `LMD_CLK_MHZ,
  parameter int BLINK_TICK_CYC = `LMD_BLINK_TICK_MS * 1000 * `LMD_CLK_MHZ
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Link to the host.
  lmd_link_if.dev lnk,
  // Segment (row) lines, two signals per pin.
  output logic [15:0] segLineOut,
  output logic [15:0] segLineOe,
  // Column drive lines, two signals per pin.
  output logic [7:0] colDriveOut,
  output logic [7:0] colDriveOe
);
  // Gap length in cycles; exact at the core rate, so no rounding is lost.
  localparam int BLANK_CYC = `LMD_BLANK_US * `LMD_CLK_MHZ;
  localparam int SW = $clog2(SLOT_CYC + 1);
  localparam int BW = $clog2(BLINK_TICK_CYC + 1);

  // Two-stage synchronisers for link clock, select and data, in that order.
  logic [2:0] syncA_r;
  logic [2:0] syncB_r;
  logic clkPrev_r; // Previous synchronised link clock, for edge detection.
  logic linkRise; // Rising link clock seen this cycle.
  logic linkFall; // Falling link clock seen this cycle.
  logic linkSel; // Frame in progress.
  logic linkBit; // Synchronised host data bit.

  // Link receive and transmit state.
  logic dirKnown_r, dirKnown_nxt; // First bit of the frame has been taken.
  logic rdFrame_r, rdFrame_nxt; // Frame is a read frame.
  logic cmdSeen_r, cmdSeen_nxt; // First byte of a write frame decoded.
  logic dataOk_r, dataOk_nxt; // A pointer command opened a data phase.
  logic [2:0] bitCnt_r, bitCnt_nxt; // Received bits of the current byte.
  logic [7:0] rxSh_r, rxSh_nxt; // Receive shifter.
  logic [7:0] txSh_r, txSh_nxt; // Transmit shifter.
  logic [2:0] txCnt_r, txCnt_nxt; // Bits still to send of the current byte.
  logic d2h_r, d2h_nxt; // Registered link output.
  logic [6:0] ptr_r, ptr_nxt; // Address pointer.
  logic [7:0] byteVal; // Byte completed by the current bit.
  logic [7:0] rdByte; // Byte at the pointer for reads.

  // Configuration state.
  logic oscOn_r, oscOn_nxt; // System oscillator running; low means standby.
  logic [7:0] dispCfg_r, dispCfg_nxt; // Display configuration byte.

  // Display RAM and its write port.
  logic [7:0] ram_r [16];
  logic ramWe;
  logic [3:0] ramAddr;

  // Frame and blink timing.
  logic [SW-1:0] slotCnt_r, slotCnt_nxt; // Cycle within the current slot.
  logic [3:0] slot_r, slot_nxt; // Slot 0-7 columns, 8 key scan.
  logic [BW-1:0] blinkCnt_r, blinkCnt_nxt; // Divider to the blink base tick.
  logic [2:0] blinkDiv_r, blinkDiv_nxt; // Binary divider of base ticks.

  // Pin drive.
  logic [15:0] segOut_nxt, segOe_nxt;
  logic [7:0] colOut_nxt, colOe_nxt;
  logic [1:0] blinkSel;
  logic blinkOff, keySlot, showing, inGap;
  logic [2:0] col;

  // Synchronisers; only the second stage and the edge flop read further on.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      syncA_r <= 3'h6;
      syncB_r <= 3'h6;
      clkPrev_r <= 1'b1;
    end else begin
      syncA_r <= {lnk.lnkClk, lnk.lnkSelN, lnk.lnkH2d};
      syncB_r <= syncA_r;
      clkPrev_r <= syncB_r[2];
    end
  end

  assign linkRise = syncB_r[2] & ~clkPrev_r;
  assign linkFall = ~syncB_r[2] & clkPrev_r;
  assign linkSel = ~syncB_r[1];
  assign linkBit = syncB_r[0];
  assign byteVal = {rxSh_r[6:0], linkBit};
  // Key data and flag space read as zero; their content belongs to the key scanner.
  assign rdByte = (ptr_r < `LMD_RAM_WORDS) ? ram_r[ptr_r[3:0]] : 8'h00;

  // Link and command logic: computes every next value of the link group.
  always_comb begin
    dirKnown_nxt = dirKnown_r;
    rdFrame_nxt = rdFrame_r;
    cmdSeen_nxt = cmdSeen_r;
    dataOk_nxt = dataOk_r;
    bitCnt_nxt = bitCnt_r;
    rxSh_nxt = rxSh_r;
    txSh_nxt = txSh_r;
    txCnt_nxt = txCnt_r;
    d2h_nxt = d2h_r;
    ptr_nxt = ptr_r;
    oscOn_nxt = oscOn_r;
    dispCfg_nxt = dispCfg_r;
    ramWe = 1'b0;
    ramAddr = ptr_r[3:0];
    if (!linkSel) begin
      // Between frames the frame flags other than rdFrame_r and the bit counters return to the start of a frame.
      dirKnown_nxt = 1'b0;
      cmdSeen_nxt = 1'b0;
      dataOk_nxt = 1'b0;
      bitCnt_nxt = 3'h0;
      txCnt_nxt = 3'h0;
    end else begin
      if (linkRise) begin
        if (!dirKnown_r) begin
          // First bit of a frame selects read or write.
          dirKnown_nxt = 1'b1;
          rdFrame_nxt = linkBit;
        end else if (!rdFrame_r) begin
          rxSh_nxt = byteVal;
          bitCnt_nxt = bitCnt_r + 3'h1;
          if (bitCnt_r == 3'h7) begin
            cmdSeen_nxt = 1'b1;
            if (!cmdSeen_r) begin
              // First byte of a write frame is a command.
              case (byteVal[7:4])
                LMD_CMD_SYS: begin
                  oscOn_nxt = byteVal[`LMD_SYS_OSC];
                end
                LMD_CMD_DISP: begin
                  // Standby refuses it; the don't-care bit is kept but unused.
                  if (oscOn_r) begin
                    dispCfg_nxt = byteVal;
                  end
                end
                LMD_CMD_DPTR, LMD_CMD_KPTR, LMD_CMD_FPTR: begin
                  if (oscOn_r) begin
                    ptr_nxt = byteVal[6:0];
                    dataOk_nxt = 1'b1;
                  end
                end
                default: begin
                  // Dimming, row/interrupt and unknown commands belong elsewhere.
                end
              endcase
            end else if (dataOk_r && oscOn_r) begin
              // Data bytes land at the pointer; key and flag space ignore writes.
              ramWe = (ptr_r < `LMD_RAM_WORDS);
              ptr_nxt = ptr_r + 7'h01;
            end
          end
        end
      end
      if (linkFall && dirKnown_r && rdFrame_r) begin
        if (txCnt_r == 3'h0) begin
          // Start of a byte: fetch at the pointer and move on.
          txSh_nxt = {rdByte[6:0], 1'b0};
          d2h_nxt = rdByte[7];
          ptr_nxt = ptr_r + 7'h01;
          txCnt_nxt = 3'h7;
        end else begin
          d2h_nxt = txSh_r[7];
          txSh_nxt = {txSh_r[6:0], 1'b0};
          txCnt_nxt = txCnt_r - 3'h1;
        end
      end
    end
  end

  // Link and command registers; the oscillator is stopped from reset.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dirKnown_r <= 1'b0;
      rdFrame_r <= 1'b0;
      cmdSeen_r <= 1'b0;
      dataOk_r <= 1'b0;
      bitCnt_r <= 3'h0;
      rxSh_r <= 8'h00;
      txSh_r <= 8'h00;
      txCnt_r <= 3'h0;
      d2h_r <= 1'b0;
      ptr_r <= 7'h00;
      oscOn_r <= 1'b0;
      dispCfg_r <= `LMD_DISP_CFG_RST;
    end else begin
      dirKnown_r <= dirKnown_nxt;
      rdFrame_r <= rdFrame_nxt;
      cmdSeen_r <= cmdSeen_nxt;
      dataOk_r <= dataOk_nxt;
      bitCnt_r <= bitCnt_nxt;
      rxSh_r <= rxSh_nxt;
      txSh_r <= txSh_nxt;
      txCnt_r <= txCnt_nxt;
      d2h_r <= d2h_nxt;
      ptr_r <= ptr_nxt;
      oscOn_r <= oscOn_nxt;
      dispCfg_r <= dispCfg_nxt;
    end
  end

  // Display RAM; cleared at reset so a blank panel shows before any write.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        ram_r[i] <= 8'h00;
      end
    end else if (ramWe) begin
      ram_r[ramAddr] <= byteVal;
    end
  end

  // Frame and blink timing: everything counts core cycles; in standby the slot counters clear and the blink divider holds.
  always_comb begin
    slotCnt_nxt = slotCnt_r;
    slot_nxt = slot_r;
    blinkCnt_nxt = blinkCnt_r;
    blinkDiv_nxt = blinkDiv_r;
    if (!oscOn_r) begin
      // Standby restarts the frame at column 0 when the oscillator comes back.
      slotCnt_nxt = '0;
      slot_nxt = 4'h0;
    end else begin
      if (slotCnt_r == SW'(SLOT_CYC - 1)) begin
        slotCnt_nxt = '0;
        slot_nxt = (slot_r == `LMD_KEYSCAN_SLOT) ? 4'h0 : slot_r + 4'h1;
      end else begin
        slotCnt_nxt = slotCnt_r + SW'(1);
      end
      if (blinkCnt_r == BW'(BLINK_TICK_CYC - 1)) begin
        blinkCnt_nxt = '0;
        blinkDiv_nxt = blinkDiv_r + 3'h1;
      end else begin
        blinkCnt_nxt = blinkCnt_r + BW'(1);
      end
    end
  end

  // Timing registers.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slotCnt_r <= '0;
      slot_r <= 4'h0;
      blinkCnt_r <= '0;
      blinkDiv_r <= 3'h0;
    end else begin
      slotCnt_r <= slotCnt_nxt;
      slot_r <= slot_nxt;
      blinkCnt_r <= blinkCnt_nxt;
      blinkDiv_r <= blinkDiv_nxt;
    end
  end

  // Blink: bit 0 of the divider toggles at 2 Hz, bit 1 at 1 Hz, bit 2 at 0.5 Hz.
  assign blinkSel = dispCfg_r[`LMD_CFG_BLINK_HI:`LMD_CFG_BLINK_LO];
  assign blinkOff = (blinkSel != 2'b00) && blinkDiv_r[2'(blinkSel - 2'b01)];
  assign keySlot = !oscOn_r || (slot_r == `LMD_KEYSCAN_SLOT);
  assign showing = dispCfg_r[`LMD_CFG_EN] && !blinkOff;
  assign inGap = slotCnt_r < SW'(BLANK_CYC);
  assign col = slot_r[2:0];

  // Rows carry the two bytes of the current column; floating otherwise.
  always_comb begin
    segOut_nxt = {ram_r[{col, 1'b1}], ram_r[{col, 1'b0}]};
    segOe_nxt = {16{!keySlot && showing && !inGap}};
  end

  // Per column: low in its own slot, key-scan lines high outside display slots.
  for (genvar c = 0; c < 8; c++) begin : g_col
    localparam logic KSL = (c < 4);
    assign colOe_nxt[c] = keySlot ? KSL : (showing && !inGap && col == 3'(c));
    assign colOut_nxt[c] = keySlot ? KSL : 1'b0;
  end

  // Pin registers; after reset columns 0-3 sit high and the rest float.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      segLineOut <= 16'h0000;
      segLineOe <= 16'h0000;
      colDriveOut <= 8'h0F;
      colDriveOe <= 8'h0F;
    end else begin
      segLineOut <= segOut_nxt;
      segLineOe <= segOe_nxt;
      colDriveOut <= colOut_nxt;
      colDriveOe <= colOe_nxt;
    end
  end

  assign lnk.lnkD2h = d2h_r;
endmodule // lmd_dev_end

/* verilog/lmd_host_end.sv */
// Host end: Avalon-MM register slave that sends command and data bytes over the link.
`timescale 1ns/1ns
`include "lmd_map.svh"
module lmd_host_end import lmd_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Avalon-MM slave, word addressed.
  input wire logic [1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  // Link to the device.
  lmd_link_if.host lnk
);
  lmd_hst_e st_r, st_nxt; // Link sequencer state.
  logic [3:0] ph_r, ph_nxt; // Cycle within the current half period.
  logic [8:0] sh_r, sh_nxt; // Bits still to send, most significant first.
  logic [3:0] nb_r, nb_nxt; // Link clocks left in this request.
  logic [7:0] rx_r, rx_nxt; // Bits gathered from the device.
  logic open_r, open_nxt; // A frame is open.
  logic last_r, last_nxt; // Close the frame after this request.
  logic clk_r, clk_nxt; // Link clock out.
  logic selN_r, selN_nxt; // Frame select out.
  logic h2d_r, h2d_nxt; // Data out.
  logic wait_r, wait_nxt; // Waitrequest, low for exactly one accepting cycle.
  logic [31:0] rdata_r, rdata_nxt; // Read data.
  logic d2hA_r, d2hB_r; // Synchroniser for the device data line.
  logic [8:0] newSh; // Shifter loaded by an accepted request.
  logic takeTx; // A transmit write is accepted this edge.

  // Device data comes from another domain; two flops before use.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      d2hA_r <= 1'b0;
      d2hB_r <= 1'b0;
    end else begin
      d2hA_r <= lnk.lnkD2h;
      d2hB_r <= d2hA_r;
    end
  end

  assign takeTx = avsWrite && !wait_r && (avsAddress == `LMD_REG_TX);

  // Bus slave and link sequencer next values.
  always_comb begin
    st_nxt = st_r;
    ph_nxt = ph_r;
    sh_nxt = sh_r;
    nb_nxt = nb_r;
    rx_nxt = rx_r;
    open_nxt = open_r;
    last_nxt = last_r;
    clk_nxt = clk_r;
    selN_nxt = selN_r;
    h2d_nxt = h2d_r;
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    newSh = 9'h000;
    // Reads answer at once; a transmit write waits until the link is idle.
    if (wait_r && (avsRead || (avsWrite && (avsAddress != `LMD_REG_TX || st_r == LMD_H_IDLE)))) begin
      wait_nxt = 1'b0;
      if (avsRead && avsAddress == `LMD_REG_STAT) begin
        rdata_nxt = {16'h0000, rx_r, 6'h00, open_r, st_r != LMD_H_IDLE};
      end else begin
        // Unmapped reads and the write-only transmit register read zero.
        rdata_nxt = 32'h0000_0000;
      end
    end
    case (st_r)
      LMD_H_IDLE: begin
        if (takeTx) begin
          last_nxt = avsWritedata[`LMD_TX_LAST];
          if (!open_r) begin
            // A new frame leads with its direction bit, one extra clock.
            newSh = {avsWritedata[`LMD_TX_READ], avsWritedata[7:0]};
            nb_nxt = 4'h9;
          end else begin
            newSh = {avsWritedata[7:0], 1'b0};
            nb_nxt = 4'h8;
          end
          open_nxt = 1'b1;
          selN_nxt = 1'b0;
          clk_nxt = 1'b0;
          h2d_nxt = newSh[8];
          sh_nxt = {newSh[7:0], 1'b0};
          ph_nxt = 4'h0;
          st_nxt = LMD_H_LOW;
        end
      end
      LMD_H_LOW: begin
        ph_nxt = ph_r + 4'h1;
        if (ph_r == `LMD_LNK_HALF - 4'h1) begin
          ph_nxt = 4'h0;
          clk_nxt = 1'b1;
          st_nxt = LMD_H_HIGH;
        end
      end
      LMD_H_HIGH: begin
        ph_nxt = ph_r + 4'h1;
        if (ph_r == `LMD_LNK_HALF - 4'h1) begin
          // Sample late in the high half so the device has settled.
          ph_nxt = 4'h0;
          rx_nxt = {rx_r[6:0], d2hB_r};
          nb_nxt = nb_r - 4'h1;
          if (nb_r == 4'h1) begin
            if (last_r) begin
              selN_nxt = 1'b1;
              open_nxt = 1'b0;
              st_nxt = LMD_H_CLOSE;
            end else begin
              st_nxt = LMD_H_IDLE;
            end
          end else begin
            clk_nxt = 1'b0;
            h2d_nxt = sh_r[8];
            sh_nxt = {sh_r[7:0], 1'b0};
            st_nxt = LMD_H_LOW;
          end
        end
      end
      LMD_H_CLOSE: begin
        // Keep select high for a half period so frames stay apart.
        ph_nxt = ph_r + 4'h1;
        if (ph_r == `LMD_LNK_HALF - 4'h1) begin
          ph_nxt = 4'h0;
          st_nxt = LMD_H_IDLE;
        end
      end
      default: begin
        st_nxt = LMD_H_IDLE;
      end
    endcase
  end

  // Registers; the link idles with clock and select high.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= LMD_H_IDLE;
      ph_r <= 4'h0;
      sh_r <= 9'h000;
      nb_r <= 4'h0;
      rx_r <= 8'h00;
      open_r <= 1'b0;
      last_r <= 1'b0;
      clk_r <= 1'b1;
      selN_r <= 1'b1;
      h2d_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      sh_r <= sh_nxt;
      nb_r <= nb_nxt;
      rx_r <= rx_nxt;
      open_r <= open_nxt;
      last_r <= last_nxt;
      clk_r <= clk_nxt;
      selN_r <= selN_nxt;
      h2d_r <= h2d_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avsReaddata = rdata_r;
  assign avsWaitrequest = wait_r;
  assign lnk.lnkClk = clk_r;
  assign lnk.lnkSelN = selN_r;
  assign lnk.lnkH2d = h2d_r;
endmodule // lmd_host_end

/* tb/lmd_assertions.sv */
// Checker for the link wires and the drive lines of the display end.
`timescale 1ns/1ns
module lmd_assertions (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Link signals.
  input wire logic lnkClk,
  input wire logic lnkSelN,
  input wire logic lnkH2d,
  input wire logic lnkD2h,
  // Drive lines of the display end.
  input wire logic [15:0] segLineOe,
  input wire logic [7:0] colDriveOut,
  input wire logic [7:0] colDriveOe
);
  logic clkPrev_r; // Link clock one cycle ago, used to find its falls.
  logic clkPrev_nxt; // Next value of the previous link clock.
  logic [7:0] bitCnt_r; // Link clock falls seen in the current frame.
  logic [7:0] bitCnt_nxt; // Next value of the fall count.

  // The count is cleared only between frames, so it still holds the total when select rises.
  always_comb begin
    clkPrev_nxt = lnkClk;
    bitCnt_nxt = bitCnt_r;
    if (lnkSelN) begin
      bitCnt_nxt = 8'h00;
    end else if (clkPrev_r && !lnkClk) begin
      bitCnt_nxt = bitCnt_r + 8'h01;
    end
  end

  // Registers of the helper logic, idle values during reset.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clkPrev_r <= 1'b1;
      bitCnt_r <= 8'h00;
    end else begin
      clkPrev_r <= clkPrev_nxt;
      bitCnt_r <= bitCnt_nxt;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_clk_idle_high: assert property (lnkSelN |-> lnkClk)
    else $error("Link clock low outside a frame.");
  a_frame_whole_bytes: assert property ($rose(lnkSelN) |-> bitCnt_r[2:0] == 3'h1)
    else $error("Frame did not hold a direction bit and whole bytes.");
  a_h2d_steady_rise: assert property (($rose(lnkClk) && !lnkSelN) |-> $stable(lnkH2d))
    else $error("Host data moved at a rising link clock.");
  a_d2h_steady_rise: assert property (($rose(lnkClk) && !lnkSelN) |-> $stable(lnkD2h))
    else $error("Device data moved at a rising link clock.");
  a_clk_low_half: assert property ($fell(lnkClk) |-> (!lnkClk) [*8] ##1 lnkClk)
    else $error("Link clock low phase is not eight cycles.");
  a_one_column_low: assert property ($onehot0(colDriveOe & ~colDriveOut))
    else $error("More than one column pulled low.");
  a_rows_need_column: assert property ((segLineOe != 16'h0000) |-> $onehot(colDriveOe & ~colDriveOut))
    else $error("Rows driven without exactly one column low.");
  a_key_rows_input: assert property ((colDriveOe == 8'h0F && colDriveOut[3:0] == 4'hF) |-> segLineOe == 16'h0000)
    else $error("Rows driven during the key-scan slot.");
  a_upper_never_high: assert property ((colDriveOe[7:4] & colDriveOut[7:4]) == 4'h0)
    else $error("Upper column driven high.");
endmodule // lmd_assertions

/* tb/tb_top.sv */
// Self-checking bench joining the host end and the display end over the link.
`timescale 1ns/1ns
`include "lmd_map.svh"
module tb_top;
  localparam int SLOT = 400; // Shortened slot so a run stays brief.
  localparam int TICK = 2000; // Shortened blink tick.
  localparam int GAP = `LMD_BLANK_US * `LMD_CLK_MHZ; // All-off gap at the head of a column slot.
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] avsAddress = 2'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic [15:0] segLineOut;
  logic [15:0] segLineOe;
  logic [7:0] colDriveOut;
  logic [7:0] colDriveOe;
  int miscompares = 0; // Mismatches seen.
  int totalChecks = 0; // Comparisons made.
  logic [15:0] shReg = 16'h0; // Host data bits captured at rising link clock.
  int nBits = 0; // Bits captured in the current frame.
  logic clkSeen = 1'b1;
  logic selSeen = 1'b1;
  logic [31:0] st;
  logic [7:0] b;
  int n;
  int run;
  int maxRun;
  int modes[4] = '{1, 2, 3, 0};

  lmd_link_if lnkBus();
  lmd_host_end lmd_host_end_i (.core_clk(core_clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .lnk(lnkBus));
  lmd_dev_end #(.SLOT_CYC(SLOT), .BLINK_TICK_CYC(TICK)) lmd_dev_end_i (.core_clk(core_clk), .rst(rst), .lnk(lnkBus),
    .segLineOut(segLineOut), .segLineOe(segLineOe), .colDriveOut(colDriveOut), .colDriveOe(colDriveOe));
  lmd_assertions lmd_assertions_i (.core_clk(core_clk), .rst(rst), .lnkClk(lnkBus.lnkClk), .lnkSelN(lnkBus.lnkSelN),
    .lnkH2d(lnkBus.lnkH2d), .lnkD2h(lnkBus.lnkD2h), .segLineOe(segLineOe), .colDriveOut(colDriveOut),
    .colDriveOe(colDriveOe));

  // Core clock, 100 ns period.
  always #50 core_clk = ~core_clk;

  // Captures host data on each rising link clock, so bit order on the wire can be compared.
  always @(posedge core_clk) begin
    clkSeen <= lnkBus.lnkClk;
    selSeen <= lnkBus.lnkSelN;
    if (selSeen && !lnkBus.lnkSelN) begin
      nBits <= 0;
    end else if (!lnkBus.lnkSelN && lnkBus.lnkClk && !clkSeen) begin
      shReg <= {shReg[14:0], lnkBus.lnkH2d};
      nBits <= nBits + 1;
    end
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic endOfTest();
    if (miscompares == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One Avalon transfer; the request is held until waitrequest is sampled low, then one idle edge follows.
  task automatic avsXfer(input logic [1:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    @(posedge core_clk);
    while (avsWaitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    q = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge core_clk);
  endtask

  // Sends one byte over the link; last closes the frame, rd opens a read frame.
  task automatic tx(input logic [7:0] v, input logic last, input logic rd);
    logic [31:0] d;
    logic [31:0] q;
    d = 32'h0;
    d[7:0] = v;
    d[`LMD_TX_LAST] = last;
    d[`LMD_TX_READ] = rd;
    avsXfer(`LMD_REG_TX, 1'b1, d, q);
  endtask

  // Polls status until the link is idle; only the watchdog cuts a hang, and it counts as a mismatch.
  task automatic waitIdle(output logic [31:0] q);
    avsXfer(`LMD_REG_STAT, 1'b0, 32'h0, q);
    while (q[`LMD_ST_BUSY] !== 1'b0) begin
      avsXfer(`LMD_REG_STAT, 1'b0, 32'h0, q);
    end
  endtask

  // One-byte command frame.
  task automatic cmd(input logic [7:0] v);
    tx(v, 1'b1, 1'b0);
    waitIdle(st);
  endtask

  // Reads one byte in a read frame.
  task automatic rdByte(input logic last, output logic [7:0] v);
    tx(8'h00, last, 1'b1);
    waitIdle(st);
    v = st[15:8];
  endtask

  // Waits until the column enables show a value, counting the edges waited.
  task automatic waitCol(input logic [7:0] v, output int k);
    k = 0;
    while (colDriveOe !== v) begin
      @(posedge core_clk);
      k++;
    end
  endtask

  // Distinct test pattern for each display byte.
  function automatic logic [7:0] pat(input int i);
    return 8'h35 + 8'(i * 29);
  endfunction

  // Main sequence.
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2 * SLOT) @(posedge core_clk);
    chk("colOe", 8'h0F, colDriveOe);
    chk("colOut", 8'h0F, colDriveOut);
    chk("segOe", 16'h0, segLineOe);
    // Standby must drop the data write and the display command.
    tx(8'h00, 1'b0, 1'b0);
    tx(8'hFF, 1'b1, 1'b0);
    waitIdle(st);
    cmd(8'h81);
    cmd(8'h21);
    chk("h2dBits", 9, nBits);
    chk("h2dOrder", 9'h021, shReg[8:0]);
    chk("linkIdle", 2'b11, {lnkBus.lnkClk, lnkBus.lnkSelN});
    n = 0;
    run = 0;
    repeat (9 * SLOT) begin
      @(posedge core_clk);
      if (segLineOe !== 16'h0 || (colDriveOe !== 8'h00 && colDriveOe !== 8'h0F)) n++;
      if (colDriveOe === 8'h00) run++;
    end
    chk("offDrive", 0, n);
    chk("offSlots", 8 * SLOT, run);
    cmd(8'h00);
    rdByte(1'b1, b);
    chk("ramKept", 8'h00, b);
    tx(8'h00, 1'b0, 1'b0);
    for (int i = 0; i < 16; i++) tx(pat(i), i == 15, 1'b0);
    waitIdle(st);
    cmd(8'h00);
    for (int i = 0; i < 16; i++) begin
      rdByte(i == 15, b);
      chk("ram", pat(i), b);
    end
    cmd(8'h40);
    rdByte(1'b1, b);
    chk("keyData", 8'h00, b);
    cmd(8'h60);
    rdByte(1'b1, b);
    chk("flag", 8'h00, b);
    cmd(8'h89);
    waitCol(8'h0F, n);
    for (int c = 0; c < 8; c++) begin
      waitCol(8'(8'h01 << c), n);
      if (c > 0) chk("gap", GAP, n);
      chk("rows", {pat(2 * c + 1), pat(2 * c)}, segLineOut);
      chk("rowsOe", 16'hFFFF, segLineOe);
      chk("colLow", 1'b0, colDriveOut[c]);
      waitCol((c == 7) ? 8'h0F : 8'h00, n);
      chk("slot", SLOT - GAP, n);
    end
    waitCol(8'h00, n);
    chk("keySlot", SLOT, n);
    // Longest dark run per blink mode; mode 0 leaves only the key slot plus one gap.
    foreach (modes[j]) begin
      cmd({4'h8, 1'b0, 2'(modes[j]), 1'b1});
      run = 0;
      maxRun = 0;
      repeat ((modes[j] > 0) ? (2 << modes[j]) * TICK : 18 * SLOT) begin
        @(posedge core_clk);
        run = (segLineOe === 16'h0) ? run + 1 : 0;
        if (run > maxRun) maxRun = run;
      end
      if (modes[j] == 0) chk("darkRun", SLOT + GAP, maxRun);
      else chk("blinkRun", 1, maxRun >= (TICK << (modes[j] - 1)) && maxRun <= (TICK << (modes[j] - 1)) + SLOT + GAP);
    end
    cmd(8'h20);
    n = 0;
    repeat (2 * SLOT) begin
      @(posedge core_clk);
      if (colDriveOe !== 8'h0F || segLineOe !== 16'h0) n++;
    end
    chk("standby", 0, n);
    endOfTest();
  end

  // Watchdog: a clean run takes about 83,000 cycles, so 95,000 leaves margin and still ends a hang early.
  initial begin
    #(95000 * 100);
    miscompares++;
    endOfTest();
  end
endmodule // tb_top
